// file: rtcal_alarm_regs.sv
`timescale 1ns/10ps
// How it works
// - Minutes register bit 7 low enables minute alarm; resets high (disabled).
// - Minutes register bits 6..0 hold BCD minute, 00 to 59.
// - Reads always return contents; writes dropped while password protection active.
// - Hours register bit 7 low enables hour alarm; resets high (disabled).
// - In 24-hour mode hours bits 5..0 hold BCD hour 0 to 23.
// - In 12-hour mode bit 5 is afternoon flag, bits 4..0 BCD hour.
// - Hours register bit 6 is read-only and always reads zero.
// - Day register has its own enable, joined with minute and hour enables.
// - Minute enable acts jointly with hour and day enables for alarm.
// - Day select low makes the day register a weekday alarm.
// - Weekday alarm value is BCD 0 to 6, meaning chosen by software.
// - Day select high makes the day register a date alarm 01 to 31.
// - Date alarm value is passed as is; leap-year handling belongs to the calendar counter.
// - Day register bit 7 low enables day alarm; resets high (disabled).
// - Weekday value sits in bits 2..0; bits 6..3 read zero.
module rtcal_alarm_regs #(
   parameter int DATA_W = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic write_protect,
   input wire logic twelve_hour_select,
   input wire logic weekday_or_date_select,
   output logic [DATA_W-1:0] reg_rdata,
   output logic minute_alarm_disable,
   output logic hour_alarm_disable,
   output logic day_alarm_disable,
   output logic alarm_armed,
   output logic [6:0] minute_value,
   output logic [5:0] hour_value,
   output logic afternoon_flag,
   output logic [5:0] day_value
);
   // ****************************************
   // Parameter check
   // ****************************************
   // The bit layout is fixed at one byte per register
   if (DATA_W != 8) begin : g_bad_width
      $error("rtcal_alarm_regs: DATA_W must be 8");
   end

   // ****************************************
   // Limitations
   // ****************************************
   // No BCD range check on writes; software keeps values legal
   // Date 00 after power-on is kept until the host writes a real date
   // Leap-year handling belongs to the calendar counter
   // Decoded outputs follow the mode selects one cycle late
   // Read and write of one register in one cycle: read sees old byte
   // Unmapped writes vanish without any indication

   // ****************************************
   // Stored registers
   // ****************************************
   // One entry per alarm register: address, value after reset, writable bits
   localparam int NUM_REGS = 3;
   localparam logic [7:0] ENTRY_ADDR [NUM_REGS] = '{rtcal_pkg::MIN_ALARM_ADDR,
      rtcal_pkg::HOUR_ALARM_ADDR, rtcal_pkg::DAY_ALARM_ADDR};
   localparam logic [7:0] ENTRY_RST [NUM_REGS] = '{rtcal_pkg::MIN_ALARM_RST,
      rtcal_pkg::HOUR_ALARM_RST, rtcal_pkg::DAY_ALARM_RST};
   localparam logic [7:0] ENTRY_WMASK [NUM_REGS] = '{rtcal_pkg::MIN_ALARM_WMASK,
      rtcal_pkg::HOUR_ALARM_WMASK, rtcal_pkg::DAY_ALARM_WMASK};
   // Positions of the three registers in the tables above
   localparam int MIN_IDX = 0;
   localparam int HOUR_IDX = 1;
   localparam int DAY_IDX = 2;

   // A reset value may not set a bit that writes can never set
   for (genvar c = 0; c < NUM_REGS; c++) begin : g_rst_check
      if ((ENTRY_RST[c] & ~ENTRY_WMASK[c]) != 8'h00) begin : g_bad_rst
         $error("rtcal_alarm_regs: reset value sets a read-only bit");
      end
   end

   logic [7:0] entry_q [NUM_REGS];
   logic [7:0] entry_d [NUM_REGS];
   logic [7:0] min_q, min_d;
   logic [7:0] hour_q, hour_d;
   logic [7:0] day_q, day_d;
   logic wr_ok;

   // Protection blocks writes but never reads
   assign wr_ok = reg_wr && !write_protect;

   // Same write and storage logic for each register
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_entry
      logic [7:0] store_q, store_d;

      // Masked write data on an address hit, otherwise hold
      always_comb begin
         store_d = store_q;
         if (wr_ok && reg_addr == ENTRY_ADDR[g]) begin
            // Read-only bits dropped; whole byte kept so a mode flip loses nothing
            store_d = reg_wdata & ENTRY_WMASK[g];
         end
      end

      // Storage, reset to disabled alarms
      always_ff @(posedge clk) begin
         if (srst) begin
            store_q <= ENTRY_RST[g];
         end else begin
            store_q <= store_d;
         end
      end

      assign entry_q[g] = store_q;
      assign entry_d[g] = store_d;
   end

   // Named views of the three entries
   assign min_q = entry_q[MIN_IDX];
   assign min_d = entry_d[MIN_IDX];
   assign hour_q = entry_q[HOUR_IDX];
   assign hour_d = entry_d[HOUR_IDX];
   assign day_q = entry_q[DAY_IDX];
   assign day_d = entry_d[DAY_IDX];

   // ****************************************
   // Read data and decoded alarm fields
   // ****************************************
   logic [7:0] rdata_q, rdata_d;
   logic [7:0] day_view;
   logic [6:0] minv_q, minv_d;
   logic [5:0] hourv_q, hourv_d;
   logic [5:0] dayv_q, dayv_d;
   logic pm_q, pm_d;
   logic dis_m_q, dis_h_q, dis_w_q, armed_q;
   logic dis_m_d, dis_h_d, dis_w_d, armed_d;

   // Mode selects only change how the stored bytes are viewed
   always_comb begin
      if (weekday_or_date_select) begin
         // Date view: value field in bits 5..0
         day_view = day_q;
         dayv_d = 6'(day_d & rtcal_pkg::DATE_VAL_MASK);
      end else begin
         // Weekday view: bits 6..3 hidden; bits 5..3 still stored, bit 6 never stored
         day_view = day_q & rtcal_pkg::WEEKDAY_RD_MASK;
         dayv_d = 6'(day_d & rtcal_pkg::WEEKDAY_VAL_MASK);
      end
      if (twelve_hour_select) begin
         // 12-hour view: afternoon flag split off the hour
         hourv_d = 6'(hour_d & rtcal_pkg::HOUR_VAL12_MASK);
         pm_d = hour_d[rtcal_pkg::AFTERNOON_BIT];
      end else begin
         // 24-hour view: no afternoon flag
         hourv_d = 6'(hour_d & rtcal_pkg::HOUR_VAL24_MASK);
         pm_d = 1'b0;
      end
      minv_d = min_d[6:0];
      // Enables leave as stored, whatever the mode
      dis_m_d = min_d[rtcal_pkg::DISABLE_BIT];
      dis_h_d = hour_d[rtcal_pkg::DISABLE_BIT];
      dis_w_d = day_d[rtcal_pkg::DISABLE_BIT];
      // Any one enabled field arms the shared alarm compare
      armed_d = !(dis_m_d && dis_h_d && dis_w_d);
      // Read port holds its last answer between reads
      rdata_d = rdata_q;
      if (reg_rd) begin
         unique case (reg_addr)
            rtcal_pkg::MIN_ALARM_ADDR: rdata_d = min_q;
            rtcal_pkg::HOUR_ALARM_ADDR: rdata_d = hour_q;
            rtcal_pkg::DAY_ALARM_ADDR: rdata_d = day_view;
            default: rdata_d = rtcal_pkg::UNMAPPED_RD;
         endcase
      end
   end

   // ****************************************
   // Decoded field registers
   // ****************************************
   // Leap-year date range is the calendar counter's job; value is passed as is
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= rtcal_pkg::UNMAPPED_RD;
         minv_q <= 7'h00;
         hourv_q <= 6'h00;
         dayv_q <= 6'h00;
         pm_q <= 1'b0;
         dis_m_q <= 1'b1;
         dis_h_q <= 1'b1;
         dis_w_q <= 1'b1;
         armed_q <= 1'b0;
      end else begin
         // Registered so every output comes from a flip-flop
         rdata_q <= rdata_d;
         minv_q <= minv_d;
         hourv_q <= hourv_d;
         dayv_q <= dayv_d;
         pm_q <= pm_d;
         dis_m_q <= dis_m_d;
         dis_h_q <= dis_h_d;
         dis_w_q <= dis_w_d;
         armed_q <= armed_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Straight from the registers above
   assign reg_rdata = rdata_q;
   assign minute_alarm_disable = dis_m_q;
   assign hour_alarm_disable = dis_h_q;
   assign day_alarm_disable = dis_w_q;
   assign alarm_armed = armed_q;
   assign minute_value = minv_q;
   assign hour_value = hourv_q;
   assign afternoon_flag = pm_q;
   assign day_value = dayv_q;
endmodule : rtcal_alarm_regs

// file: rtcal_pkg.sv
package rtcal_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] MIN_ALARM_ADDR = 8'h07;
   localparam logic [7:0] HOUR_ALARM_ADDR = 8'h08;
   localparam logic [7:0] DAY_ALARM_ADDR = 8'h09;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] MIN_ALARM_RST = 8'h80;
   localparam logic [7:0] HOUR_ALARM_RST = 8'h80;
   localparam logic [7:0] DAY_ALARM_RST = 8'h80;

   // ****************************************
   // Field layout
   // ****************************************
   localparam int DISABLE_BIT = 7;
   localparam int AFTERNOON_BIT = 5;
   // Writable bits; bit 6 of hours and day registers is read-only zero
   localparam logic [7:0] MIN_ALARM_WMASK = 8'hFF;
   localparam logic [7:0] HOUR_ALARM_WMASK = 8'hBF;
   localparam logic [7:0] DAY_ALARM_WMASK = 8'hBF;
   // Read and decode masks that depend on the mode selects, then the fixed unmapped read value
   localparam logic [7:0] HOUR_VAL24_MASK = 8'h3F;
   localparam logic [7:0] HOUR_VAL12_MASK = 8'h1F;
   localparam logic [7:0] WEEKDAY_RD_MASK = 8'h87;
   localparam logic [7:0] WEEKDAY_VAL_MASK = 8'h07;
   localparam logic [7:0] DATE_VAL_MASK = 8'h3F;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;
endpackage : rtcal_pkg

// file: rtcal_alarm_regs_chk.sv
`timescale 1ns/10ps
// ****************************************
// Register port checks
// ****************************************
module rtcal_alarm_regs_chk #(parameter int DATA_W = 8) (
   input wire logic clk,
   input wire logic srst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic write_protect,
   input wire logic twelve_hour_select,
   input wire logic weekday_or_date_select,
   input wire logic [7:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic minute_alarm_disable,
   input wire logic hour_alarm_disable,
   input wire logic day_alarm_disable,
   input wire logic alarm_armed,
   input wire logic afternoon_flag,
   input wire logic [6:0] minute_value,
   input wire logic [5:0] hour_value,
   input wire logic [5:0] day_value
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Accepted write and read of one address
   sequence s_wr(a); reg_wr && !write_protect && reg_addr == a; endsequence
   sequence s_rd(a); reg_rd && reg_addr == a; endsequence
   property p_min; s_wr(rtcal_pkg::MIN_ALARM_ADDR) |=> minute_alarm_disable ==
      $past(reg_wdata[7]) && minute_value == $past(reg_wdata[6:0]); endproperty
   a_min: assert property (p_min) else $error("minutes write lost");
   // Protected writes may not move the three enables or the minute value
   property p_wp; reg_wr && write_protect |=> $stable({minute_alarm_disable,
      hour_alarm_disable, day_alarm_disable, minute_value}); endproperty
   a_wp: assert property (p_wp) else $error("protected write took effect");
   property p_arm; alarm_armed == !(minute_alarm_disable && hour_alarm_disable &&
      day_alarm_disable); endproperty
   a_arm: assert property (p_arm) else $error("armed flag wrong");
   property p_h24; s_wr(rtcal_pkg::HOUR_ALARM_ADDR) ##0 !twelve_hour_select |=>
      hour_value == $past(reg_wdata[5:0]) && !afternoon_flag &&
      hour_alarm_disable == $past(reg_wdata[7]); endproperty
   a_h24: assert property (p_h24) else $error("24h hour wrong");
   property p_h12; s_wr(rtcal_pkg::HOUR_ALARM_ADDR) ##0 twelve_hour_select |=>
      hour_value == {1'h0, $past(reg_wdata[4:0])} && afternoon_flag == $past(reg_wdata[5]);
   endproperty
   a_h12: assert property (p_h12) else $error("12h hour wrong");
   property p_h7; s_rd(rtcal_pkg::HOUR_ALARM_ADDR) |=> !reg_rdata[6]; endproperty
   a_h7: assert property (p_h7) else $error("hours bit 6 set");
   property p_unm; reg_rd && (reg_addr < rtcal_pkg::MIN_ALARM_ADDR ||
      reg_addr > rtcal_pkg::DAY_ALARM_ADDR) |=>
      reg_rdata == rtcal_pkg::UNMAPPED_RD; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_wk; s_rd(rtcal_pkg::DAY_ALARM_ADDR) ##0 !weekday_or_date_select |=>
      reg_rdata[6:3] == 4'h0; endproperty
   a_wk: assert property (p_wk) else $error("weekday bits 6:3 set");
   property p_day; s_wr(rtcal_pkg::DAY_ALARM_ADDR) |=> day_alarm_disable ==
      $past(reg_wdata[7]); endproperty
   a_day: assert property (p_day) else $error("day enable lost");
   // Decoded day value in each mode
   property p_date; s_wr(rtcal_pkg::DAY_ALARM_ADDR) ##0 weekday_or_date_select |=>
      day_value == $past(reg_wdata[5:0]); endproperty
   a_date: assert property (p_date) else $error("date value wrong");
   property p_wday; s_wr(rtcal_pkg::DAY_ALARM_ADDR) ##0 !weekday_or_date_select |=>
      day_value == {3'h0, $past(reg_wdata[2:0])}; endproperty
   a_wday: assert property (p_wday) else $error("weekday value wrong");
endmodule : rtcal_alarm_regs_chk
bind rtcal_alarm_regs rtcal_alarm_regs_chk #(.DATA_W(DATA_W)) i_rtcal_alarm_regs_chk (
   .clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .write_protect(write_protect),
   .twelve_hour_select(twelve_hour_select), .weekday_or_date_select(weekday_or_date_select),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .minute_alarm_disable(minute_alarm_disable), .hour_alarm_disable(hour_alarm_disable),
   .day_alarm_disable(day_alarm_disable), .alarm_armed(alarm_armed),
   .afternoon_flag(afternoon_flag), .minute_value(minute_value), .hour_value(hour_value),
   .day_value(day_value));

// file: rtcal_host.sv
`timescale 1ns/10ps
// ****************************************
// Host side of the register port
// ****************************************
module rtcal_host (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata
);
   // Idle bus; released data is scrambled so stale values never look valid
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0_0000;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'h1};
      @(negedge clk) {reg_wdata, reg_wr} = {~d, 1'h0};
   endtask : wr
   // Read data lands one edge after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk) {reg_addr, reg_rd} = {a, 1'h1};
      @(negedge clk) {d, reg_rd} = {reg_rdata, 1'h0};
   endtask : rd
endmodule : rtcal_host

// file: rtcal_alarm_regs_tb.sv
`timescale 1ns/10ps
// ****************************************
// Register bench
// ****************************************
module rtcal_alarm_regs_tb;
   typedef struct {logic [7:0] a, d, e; logic h12, wd;} rtcal_row_t;
   logic clk, srst, wp, h12, wd, reg_wr, reg_rd;
   logic dm, dh, dd, arm, pm;
   logic [6:0] mv;
   logic [5:0] hv, dv;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   int bad_count, check_count;
   // Minutes, both hour views, weekday, date; bit 6 writes dropped
   rtcal_row_t rows [7] = '{'{8'h07, 8'h59, 8'h59, 1'h0, 1'h0},
      '{8'h07, 8'h00, 8'h00, 1'h0, 1'h0},
      '{8'h08, 8'h63, 8'h23, 1'h0, 1'h0},
      '{8'h08, 8'h32, 8'h32, 1'h1, 1'h0},
      '{8'h09, 8'h7E, 8'h06, 1'h0, 1'h0},
      '{8'h09, 8'h31, 8'h31, 1'h0, 1'h1},
      '{8'h09, 8'hC5, 8'h85, 1'h0, 1'h1}};
   rtcal_alarm_regs i_rtcal_alarm_regs (.clk(clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .write_protect(wp),
      .twelve_hour_select(h12), .weekday_or_date_select(wd), .reg_rdata(reg_rdata),
      .minute_alarm_disable(dm), .hour_alarm_disable(dh), .day_alarm_disable(dd),
      .alarm_armed(arm), .minute_value(mv), .hour_value(hv), .afternoon_flag(pm),
      .day_value(dv));
   rtcal_host i_rtcal_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic summarize;
      if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   // Rows first, then hour mode flip, second reset, protection, day mode flip, unmapped read
   initial begin
      {srst, wp, h12, wd} = 4'h8;
      repeat (5) @(negedge clk);
      srst = 1'h0;
      foreach (rows[i]) begin
         {h12, wd} = {rows[i].h12, rows[i].wd};
         i_rtcal_host.wr(rows[i].a, rows[i].d);
         i_rtcal_host.rd(rows[i].a, v);
         chk("row", v, rows[i].e);
      end
      chk("flags", {4'h0, dm, dh, dd, arm}, 8'h03);
      chk("day_val", {2'h0, dv}, 8'h05);
      h12 = 1'h1;
      i_rtcal_host.rd(8'h08, v);
      chk("hour_12", v, 8'h32);
      chk("pm_view", {1'h0, pm, hv}, 8'h52);
      srst = 1'h1;
      repeat (5) @(negedge clk);
      {srst, h12, wd} = 3'h0;
      chk("rst_flags", {4'h0, dm, dh, dd, arm}, 8'h0E);
      chk("rst_vals", {1'h0, mv} | {2'h0, hv} | {2'h0, dv} | {7'h0, pm}, 8'h00);
      for (int i = 7; i < 10; i++) begin
         i_rtcal_host.rd(8'(i), v);
         chk("reset", v, 8'h80);
      end
      wp = 1'h1;
      i_rtcal_host.wr(8'h07, 8'h15);
      i_rtcal_host.rd(8'h07, v);
      chk("protect", v, 8'h80);
      wp = 1'h0;
      i_rtcal_host.wr(8'h09, 8'h3F);
      i_rtcal_host.rd(8'h09, v);
      chk("weekday", v, 8'h07);
      chk("weekday_val", {2'h0, dv}, 8'h07);
      chk("flags_day", {4'h0, dm, dh, dd, arm}, 8'h0D);
      wd = 1'h1;
      i_rtcal_host.rd(8'h09, v);
      chk("date", v, 8'h3F);
      chk("date_val", {2'h0, dv}, 8'h3F);
      i_rtcal_host.rd(8'h0A, v);
      chk("unmapped", v, 8'h00);
      i_rtcal_host.wr(8'h07, 8'h45);
      chk("min_val", {dm, mv}, 8'h45);
      summarize();
   end
endmodule : rtcal_alarm_regs_tb
